// [pkg/spx_pkg.sv]
`default_nettype none
package spx_pkg;
  // upper three address bits of the two groups
  localparam logic [2:0] SPX_IN_GROUP = 3'h6;
  localparam logic [2:0] SPX_OUT_GROUP = 3'h5;
  // values after reset
  localparam logic [7:0] SPX_MASK_RST = 8'hff;
  localparam logic [7:0] SPX_FLAGS_RST = 8'h00;
  localparam logic [7:0] SPX_OUTS_RST = 8'h00;
  // cycle and bit counts
  localparam logic [3:0] SPX_BYTE_BITS = 4'h8;
  localparam logic [3:0] SPX_LAST_BIT = 4'h7;
  localparam logic [1:0] SPX_INIT_CYCLES = 2'h3;
  // buffered write word: group bit plus data byte
  localparam int SPX_WORD_W = 9;
  localparam int SPX_BUF_DEPTH = 2;

  // what a four-level select pin is tied to
  typedef enum logic [1:0] {
    SPX_PIN_GND = 2'h0,
    SPX_PIN_VP = 2'h1,
    SPX_PIN_SCL = 2'h2,
    SPX_PIN_SDA = 2'h3
  } spx_pin_t;

  // serial slave states, gray along the usual path
  typedef enum logic [2:0] {
    SPX_IDLE = 3'h0,
    SPX_ADDR = 3'h1,
    SPX_ADDR_ACK = 3'h3,
    SPX_WR_BYTE = 3'h2,
    SPX_WR_ACK = 3'h6,
    SPX_RD_BYTE = 3'h7,
    SPX_RD_ACK = 3'h5,
    SPX_SKIP = 3'h4
  } spx_state_t;

  // pin level seen at bus idle, at start, and at first scl low
  function automatic spx_pin_t spx_classify(input logic idle,
                                            input logic strt,
                                            input logic low);
    if (!idle) return SPX_PIN_GND;
    if (!strt) return SPX_PIN_SDA;
    if (!low) return SPX_PIN_SCL;
    return SPX_PIN_VP;
  endfunction

  // high select pin gives address bits 3:2
  function automatic logic [1:0] spx_hi_code(input spx_pin_t p);
    case (p)
      SPX_PIN_SCL: return 2'h0;
      SPX_PIN_SDA: return 2'h1;
      SPX_PIN_GND: return 2'h2;
      default: return 2'h3;
    endcase
  endfunction

  // low select pin gives address bits 1:0
  function automatic logic [1:0] spx_lo_code(input spx_pin_t p);
    case (p)
      SPX_PIN_GND: return 2'h0;
      SPX_PIN_VP: return 2'h1;
      SPX_PIN_SCL: return 2'h2;
      default: return 2'h3;
    endcase
  endfunction
endpackage
`default_nettype wire

// [pkg/spx_stream_if.sv]
`timescale 1ns/10ps
`default_nettype none
// valid/ready word stream between slave and write buffer
interface spx_stream_if
  import spx_pkg::*;
#(
  parameter int W = SPX_WORD_W
) ();
  logic valid; // word offered
  logic ready; // word can be taken
  logic [W-1:0] data; // word itself
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [design/spx_buf.sv]
`timescale 1ns/10ps
`default_nettype none
module spx_buf
  import spx_pkg::*;
#(
  parameter int W = SPX_WORD_W,
  parameter int DEPTH = SPX_BUF_DEPTH
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // streams
  spx_stream_if.snk fill,
  spx_stream_if.src drain
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // entries
    logic [AW-1:0] wp; // write pointer
    logic [AW-1:0] rp; // read pointer
    logic [AW:0] cnt; // fill level
  } spx_buf_state_t;

  spx_buf_state_t r;
  spx_buf_state_t next_r;
  logic push; // word accepted
  logic pop; // word handed on

  // full and empty come straight from the level
  assign fill.ready = (r.cnt != FULL);
  assign drain.valid = (r.cnt != '0);
  assign drain.data = r.mem[r.rp];
  assign push = fill.valid & fill.ready;
  assign pop = drain.valid & drain.ready;

  // pointer and level update
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = fill.data;
      next_r.wp = (r.wp == LAST) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      next_r.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
    end
    // simultaneous push and pop leaves the level alone
    if (push && !pop) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule // spx_buf
`default_nettype wire

// [design/spx_top.sv]
// How it works
// R1 - snapshot compared with inputs sets flags
// R2 - address acknowledge resamples inputs, clears flags
// R3 - read gives port byte, then old flags
// R4 - long reads keep alternating data and flags
// R5 - each byte pair resamples and resets flags
// R6 - mask bits gate which changes raise alert
// R7 - flags set whatever the mask says
// R8 - flags stay set until next access
// R9 - during reads alert waits for stop
// R10 - no deferred alert if change already sent
// R11 - input group 110, output group 101
// R12 - select pins map to address bits 3..0
// R13 - output defaults follow select pin levels
// R14 - eighth bit low writes, high reads
// R15 - master frames start, address, data, stop
// R16 - start and stop are sda edges, scl high
// R17 - one bit per clock, stable while high
// R18 - ninth clock carries receiver's low acknowledge
// R19 - device acks address and written bytes
// R20 - master nacks last read byte
// R21 - scl only sensed, sda open drain
// R22 - reset: mask all ones, flags clear
// R23 - input group write loads mask, clears alert
// R24 - abort returns interface to idle, keeps alert
// R25 - alert active low, latched until access
// R26 - bus lines and inputs pass synchronisers
// R27 - foreign addresses leave sda released
`timescale 1ns/10ps
`default_nettype none
module spx_top
  import spx_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // serial bus pins, sda open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic bus_abort_i,
  // four-level address select pins
  input wire logic addr_select_low_pin_i,
  input wire logic addr_select_high_pin_i,
  // port pins
  input wire logic [7:0] input_lines_i,
  output logic [7:0] output_lines_o,
  output logic alert_n_o
);
  typedef struct packed {
    logic scl_m, scl_s, scl_d; // scl sync and delay
    logic sda_m, sda_s, sda_d; // sda sync and delay
    logic abort_m, abort_s; // abort sync
    logic lo_m, lo_s, hi_m, hi_s; // select pin syncs
    logic [7:0] in_m; // input first stage
    logic [7:0] in_s; // input second stage
    logic lo_idle, hi_idle; // pin level at bus idle
    logic lo_start, hi_start; // pin level at start
    logic got_low; // first scl low seen this frame
    spx_pin_t lo_cls; // low pin connection
    spx_pin_t hi_cls; // high pin connection
    logic [1:0] init_cnt; // strap capture delay
    spx_state_t st; // slave state
    logic [3:0] cnt; // bit counter
    logic [7:0] sh; // shift register
    logic rw; // direction of this access
    logic grp; // 1 = input group
    logic odd; // next read byte is flags
    logic oe; // pulling sda low
    logic [7:0] snap; // input snapshot
    logic [7:0] flags; // input change flags
    logic [7:0] flag_cap; // flags saved for reading
    logic [7:0] mask; // change interrupt mask
    logic [7:0] outs; // output latch
    logic alert; // alert latched
    logic in_read; // read sequence running
    logic defer; // alert owed at stop
  } spx_top_state_t;

  spx_top_state_t r;
  spx_top_state_t next_r;

  // bus events and change terms
  logic start_det; // sda falls, scl high
  logic stop_det; // sda rises, scl high
  logic scl_rise;
  logic scl_fall;
  logic [7:0] diff; // live inputs against snapshot
  logic set_now; // enabled change first seen
  logic [3:0] my_addr; // address bits 3..0
  logic grp_in; // shifted address is input group
  logic addr_ok; // shifted address is ours
  logic fill_valid; // received byte pushed
  logic [SPX_WORD_W-1:0] fill_data;
  logic drain_ready; // applying buffered bytes

  spx_stream_if #(.W(SPX_WORD_W)) fill_if ();
  spx_stream_if #(.W(SPX_WORD_W)) drain_if ();

  // write bytes wait here; a full buffer makes us nack
  spx_buf #(
    .W(SPX_WORD_W),
    .DEPTH(SPX_BUF_DEPTH)
  ) u_buf (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .fill(fill_if),
    .drain(drain_if)
  );

  assign fill_if.valid = fill_valid;
  assign fill_if.data = fill_data;
  assign drain_if.ready = drain_ready;

  // edges are judged on synced and delayed copies only
  assign start_det = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s; // R16
  assign stop_det = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s; // R16
  assign scl_rise = r.scl_s & ~r.scl_d;
  assign scl_fall = ~r.scl_s & r.scl_d;
  assign diff = r.in_s ^ r.snap; // R1
  assign set_now = |(diff & ~r.flags & r.mask); // R6
  assign my_addr = {spx_hi_code(r.hi_cls), spx_lo_code(r.lo_cls)}; // R12
  assign grp_in = (r.sh[7:5] == SPX_IN_GROUP); // R11
  assign addr_ok = (grp_in || r.sh[7:5] == SPX_OUT_GROUP) &&
                   (r.sh[4:1] == my_addr); // R11 R27

  // pins: data low only, enable decides
  assign sda_o = 1'b0; // R21
  assign sda_oe_o = r.oe; // R21
  assign output_lines_o = r.outs;
  assign alert_n_o = ~r.alert; // R25

  // next state
  always_comb begin
    logic cap; // resample inputs, save and clear flags
    logic clr_al; // access clears the alert
    logic rd_go; // read sequence begins
    logic stop_al; // deferred alert fires
    logic [7:0] ld; // byte to send next
    cap = 1'b0;
    clr_al = 1'b0;
    rd_go = 1'b0;
    stop_al = 1'b0;
    ld = 8'h00;
    fill_valid = 1'b0;
    fill_data = {r.grp, r.sh};
    next_r = r;
    // two-stage synchronisers, third stage only for edges
    next_r.scl_m = scl_i; // R26
    next_r.scl_s = r.scl_m;
    next_r.scl_d = r.scl_s;
    next_r.sda_m = sda_i; // R26
    next_r.sda_s = r.sda_m;
    next_r.sda_d = r.sda_s;
    next_r.abort_m = bus_abort_i;
    next_r.abort_s = r.abort_m;
    next_r.lo_m = addr_select_low_pin_i;
    next_r.lo_s = r.lo_m;
    next_r.hi_m = addr_select_high_pin_i;
    next_r.hi_s = r.hi_m;
    next_r.in_m = input_lines_i; // R26
    next_r.in_s = r.in_m;

    // straps read once the synchronisers hold real levels
    if (r.init_cnt != SPX_INIT_CYCLES) begin
      next_r.init_cnt = r.init_cnt + 2'h1;
      if (r.init_cnt == SPX_INIT_CYCLES - 2'h1) begin
        next_r.lo_cls = r.lo_s ? SPX_PIN_VP : SPX_PIN_GND;
        next_r.hi_cls = r.hi_s ? SPX_PIN_VP : SPX_PIN_GND;
        next_r.outs[3:0] = r.lo_s ? 4'hf : 4'h0; // R13
        next_r.outs[7:4] = r.hi_s ? 4'hf : 4'h0; // R13
      end
    end

    // slave sequencing; abort beats start beats stop
    if (r.abort_s) begin
      next_r.st = SPX_IDLE; // R24
      next_r.oe = 1'b0;
    end else if (start_det) begin
      next_r.st = SPX_ADDR; // R15
      next_r.cnt = 4'h0;
      next_r.oe = 1'b0;
      next_r.lo_start = r.lo_s;
      next_r.hi_start = r.hi_s;
      next_r.got_low = 1'b0;
    end else if (stop_det) begin
      next_r.st = SPX_IDLE;
      next_r.oe = 1'b0;
      stop_al = r.in_read & r.defer; // R9 R10
    end else begin
      unique case (r.st)
        SPX_IDLE: begin
          // idle levels tell sda-tied pins from grounded ones
          if (r.scl_s && r.sda_s) begin
            next_r.lo_idle = r.lo_s;
            next_r.hi_idle = r.hi_s;
          end
        end
        SPX_ADDR: begin
          if (scl_rise) begin
            next_r.sh = {r.sh[6:0], r.sda_s}; // R17
            next_r.cnt = r.cnt + 4'h1;
          end
          if (scl_fall && !r.got_low) begin
            // re-decode the pins on every frame
            next_r.got_low = 1'b1;
            next_r.lo_cls = spx_classify(r.lo_idle, r.lo_start, r.lo_s);
            next_r.hi_cls = spx_classify(r.hi_idle, r.hi_start, r.hi_s);
          end
          if (scl_fall && r.cnt == SPX_BYTE_BITS) begin
            if (addr_ok) begin
              next_r.st = SPX_ADDR_ACK;
              next_r.oe = 1'b1; // R19 R18
              next_r.rw = r.sh[0]; // R14
              next_r.grp = grp_in;
            end else begin
              next_r.st = SPX_SKIP; // R27
            end
          end
        end
        SPX_ADDR_ACK: begin
          if (scl_rise) begin
            cap = 1'b1; // R2
            clr_al = 1'b1; // R25
            rd_go = r.rw;
          end
          if (scl_fall) begin
            next_r.cnt = 4'h0;
            if (r.rw) begin
              ld = r.grp ? r.snap : r.outs; // R3
              next_r.sh = ld;
              next_r.oe = ~ld[7];
              next_r.odd = 1'b1;
              next_r.st = SPX_RD_BYTE;
            end else begin
              next_r.oe = 1'b0;
              next_r.st = SPX_WR_BYTE;
            end
          end
        end
        SPX_WR_BYTE: begin
          if (scl_rise) begin
            next_r.sh = {r.sh[6:0], r.sda_s}; // R17
            next_r.cnt = r.cnt + 4'h1;
          end
          if (scl_fall && r.cnt == SPX_BYTE_BITS) begin
            // back-pressure: no room means no acknowledge
            if (fill_if.ready) begin
              fill_valid = 1'b1;
              next_r.oe = 1'b1; // R19
              next_r.st = SPX_WR_ACK;
            end else begin
              next_r.st = SPX_SKIP;
            end
          end
        end
        SPX_WR_ACK: begin
          if (scl_fall) begin
            next_r.oe = 1'b0;
            next_r.cnt = 4'h0;
            next_r.st = SPX_WR_BYTE;
          end
        end
        SPX_RD_BYTE: begin
          if (scl_fall) begin
            if (r.cnt == SPX_LAST_BIT) begin
              next_r.oe = 1'b0; // master owns the ack
              next_r.st = SPX_RD_ACK;
            end else begin
              next_r.sh = {r.sh[6:0], 1'b0}; // R17
              next_r.oe = ~r.sh[6];
              next_r.cnt = r.cnt + 4'h1;
            end
          end
        end
        SPX_RD_ACK: begin
          if (scl_rise) begin
            if (r.sda_s) begin
              next_r.st = SPX_SKIP; // R20
            end else if (r.grp && !r.odd) begin
              cap = 1'b1; // R5
            end
          end
          if (scl_fall) begin
            // input group alternates port byte and flags byte, output group resends outs
            if (!r.grp) begin
              ld = r.outs;
            end else if (r.odd) begin
              ld = r.flag_cap; // R3 R4
            end else begin
              ld = r.snap; // R4
            end
            next_r.sh = ld;
            next_r.oe = ~ld[7];
            next_r.odd = ~r.odd;
            next_r.cnt = 4'h0;
            next_r.st = SPX_RD_BYTE;
          end
        end
        SPX_SKIP: begin
          next_r.oe = 1'b0; // R27
        end
      endcase
    end

    // buffered writes applied; stalls while a capture runs
    drain_ready = ~cap;
    if (drain_if.valid && drain_ready) begin
      if (drain_if.data[8]) begin
        next_r.mask = drain_if.data[7:0]; // R23
        next_r.snap = r.in_s;
        next_r.flags = diff & ~r.flags; // R23
        clr_al = 1'b1; // R23
      end else begin
        next_r.outs = drain_if.data[7:0];
      end
    end

    // change flags; a change seen at a clear is kept
    if (cap) begin
      next_r.snap = r.in_s; // R2 R5
      next_r.flag_cap = r.flags | diff; // R3
      next_r.flags = SPX_FLAGS_RST; // R2
    end else if (!(drain_if.valid && drain_ready && drain_if.data[8])) begin
      next_r.flags = r.flags | diff; // R1 R7 R8
    end

    // alert: set beats clear, held back while reading
    next_r.in_read = r.in_read | rd_go;
    next_r.alert = (r.alert & ~clr_al) |
                   (set_now & ~(r.in_read | rd_go)) | stop_al; // R6 R9 R25
    if (cap) begin
      next_r.defer = 1'b0; // R10
    end else begin
      next_r.defer = r.defer | (set_now & r.in_read); // R9
    end
    if (r.abort_s || (stop_det && !start_det)) begin
      next_r.in_read = 1'b0; // R24
      next_r.defer = 1'b0;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.mask <= SPX_MASK_RST; // R22
      r.flags <= SPX_FLAGS_RST; // R22
      r.outs <= SPX_OUTS_RST;
      r.lo_cls <= SPX_PIN_VP;
      r.hi_cls <= SPX_PIN_VP;
      r.st <= SPX_IDLE;
      r.scl_s <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_s <= 1'b1;
      r.sda_d <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
endmodule // spx_top
`default_nettype wire

// [bench/spx_top_sva.sv]
`timescale 1ns/10ps
`default_nettype none
// pin-level checker for the expander core
module spx_top_sva (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic bus_abort_i,
  // select pins and ports
  input wire logic addr_select_low_pin_i,
  input wire logic addr_select_high_pin_i,
  input wire logic [7:0] input_lines_i,
  input wire logic [7:0] output_lines_o,
  input wire logic alert_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] since_rst; // cycles since reset, saturating
  // strap load lands a few cycles after reset, so latch checks wait
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      since_rst <= 4'h0;
    end else if (since_rst != 4'hf) begin
      since_rst <= since_rst + 4'h1;
    end
  end
  a_reset_quiet: assert property ($fell(rst_i) |->
    !sda_oe_o && alert_n_o && output_lines_o == 8'h00)
    else $error("pins not quiet after reset");
  a_strap_default: assert property ($fell(rst_i) |-> ##[1:8]
    output_lines_o == {{4{addr_select_high_pin_i}},
    {4{addr_select_low_pin_i}}})
    else $error("outputs missed strap default");
  a_open_drain: assert property (sda_oe_o |-> sda_o == 1'b0)
    else $error("data pin driven high");
  a_oe_stable_high: assert property (scl_i [*4] |-> $stable(sda_oe_o))
    else $error("data drive moved while clock high");
  a_abort_release: assert property ($rose(bus_abort_i) |->
    ##[1:6] !sda_oe_o)
    else $error("abort left data line pulled");
  a_abort_alert: assert property (bus_abort_i && !alert_n_o |=>
    !alert_n_o [*4])
    else $error("abort disturbed alert");
  a_alert_clear_ack: assert property ($rose(alert_n_o) |->
    ##[0:8] sda_oe_o)
    else $error("alert cleared outside an ack");
  a_out_on_ack: assert property ($changed(output_lines_o) &&
    since_rst == 4'hf |-> ##[0:8] sda_oe_o)
    else $error("outputs moved without acked write");
endmodule // spx_top_sva
bind spx_top spx_top_sva spx_top_sva_inst (
  .ref_clk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .bus_abort_i,
  .addr_select_low_pin_i, .addr_select_high_pin_i, .input_lines_i,
  .output_lines_o, .alert_n_o
);
`default_nettype wire

// [bench/spx_master.sv]
`timescale 1ns/10ps
`default_nettype none
// behavioural bus master, 64 ns bit clock, clock idles high between frames
module spx_master (
  // bus lines
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  logic [7:0] got; // last byte read
  event got_ev; // fires once per byte read
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // data changes mid low phase only
  task automatic bit_out(input logic b);
    #16 sda_o = b;
    #16 scl_o = 1'b1;
    #32 scl_o = 1'b0;
  endtask
  // release data, sample mid high phase
  task automatic bit_in(output logic b);
    #16 sda_o = 1'b1;
    #16 scl_o = 1'b1;
    #16 b = sda_i;
    #16 scl_o = 1'b0;
  endtask
  // data falls while clock high
  task automatic start;
    #32 sda_o = 1'b0;
    #32 scl_o = 1'b0;
  endtask
  // data rises while clock high, bus left idle
  task automatic stop;
    #16 sda_o = 1'b0;
    #16 scl_o = 1'b1;
    #32 sda_o = 1'b1;
    #32;
  endtask
  // msb first, then the receiver's ack
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(b);
    ack = !b;
  endtask
  // byte in, nack only on the last one
  task automatic rd_byte(input logic last);
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) begin
      bit_in(v[i]);
    end
    bit_out(last);
    got = v;
    -> got_ev;
  endtask
endmodule // spx_master
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
// bench: low select pin at V+ until the select pin test puts it on the data line, high select pin at GND
module tb_top;
  import spx_pkg::*;
  localparam logic [6:0] adr_in = {SPX_IN_GROUP, 2'h2, 2'h1};
  localparam logic [6:0] adr_out = {SPX_OUT_GROUP, 2'h2, 2'h1};
  localparam logic [6:0] adr_bad [2] = '{7'h39, {SPX_IN_GROUP, 4'h8}};
  logic ref_clk_i; // core clock
  logic rst_i; // sync reset
  logic bus_abort_i; // abort request
  logic [7:0] ins; // monitored inputs
  logic scl; // bus clock
  logic msda; // master data drive
  logic sda; // wired data line, pulled up
  logic sda_d; // core data value
  logic sda_oe; // core drives data
  logic lo_on_sda; // low select pin strapped to the data line
  logic [7:0] outs; // output latch
  logic alert_n; // alert, active low
  logic ack; // last ack seen
  logic [7:0] v; // input pattern
  logic [7:0] d; // random write byte
  logic [7:0] exp_q[$]; // bytes the master should read
  integer seed; // random seed
  int fail_count; // mismatches
  int tests_run; // comparisons
  int cyc; // cycles for the timeout
  assign sda = msda & (sda_oe ? sda_d : 1'b1);
  spx_top spx_top_inst (
    .ref_clk_i, .rst_i,
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_d),
    .sda_oe_o(sda_oe),
    .bus_abort_i,
    .addr_select_low_pin_i(lo_on_sda ? sda : 1'b1),
    .addr_select_high_pin_i(1'b0),
    .input_lines_i(ins),
    .output_lines_o(outs),
    .alert_n_o(alert_n)
  );
  spx_master spx_master_inst (.scl_o(scl), .sda_o(msda), .sda_i(sda));
  // free-running core clock
  initial begin
    ref_clk_i = 1'b0;
    forever begin
      #2.5 ref_clk_i = ~ref_clk_i;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({7'h0, g}, {7'h0, e});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // input change lands just after a clock edge
  task automatic setin(input logic [7:0] x);
    @(posedge ref_clk_i);
    #1 ins = x;
  endtask
  // start, address and direction, check the ack
  task automatic sel(input logic [6:0] a, input logic rw, input logic e);
    spx_master_inst.start();
    spx_master_inst.wr_byte({a, rw}, ack);
    chk1(ack, e);
  endtask
  task automatic wr(input logic [7:0] x);
    spx_master_inst.wr_byte(x, ack);
    chk1(ack, 1'b1);
  endtask
  // note the expected byte, then clock it in
  task automatic rd(input logic [7:0] e, input logic last);
    exp_q.push_back(e);
    spx_master_inst.rd_byte(last);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // each byte read meets the oldest note
  always @(spx_master_inst.got_ev) begin
    chk(spx_master_inst.got, exp_q.pop_front());
  end
  // hang guard, runs take well under this
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      test_done();
    end
  end
  initial begin
    rst_i = 1'b1;
    bus_abort_i = 1'b0;
    ins = 8'h00;
    lo_on_sda = 1'b0;
    seed = 32'h532c;
    repeat (3) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    wt(12);
    chk1(alert_n, 1'b1);
    chk(outs, 8'h0f);
    $display("reset test done");
    d = 8'($random(seed));
    sel(adr_out, 1'b0, 1'b1);
    wr(~d);
    wr(d);
    spx_master_inst.stop();
    wt(4);
    chk(outs, d);
    sel(adr_out, 1'b1, 1'b1);
    rd(d, 1'b0);
    rd(d, 1'b1);
    spx_master_inst.stop();
    $display("output group test done");
    foreach (adr_bad[i]) begin
      sel(adr_bad[i], 1'b0, 1'b0);
      spx_master_inst.wr_byte(d, ack);
      chk1(ack, 1'b0);
      spx_master_inst.stop();
    end
    $display("foreign address test done");
    v = 8'($random(seed));
    v[0] = 1'b1;
    setin(v);
    wt(10);
    chk1(alert_n, 1'b0);
    sel(adr_in, 1'b1, 1'b1);
    chk1(alert_n, 1'b1);
    rd(v, 1'b0);
    rd(v, 1'b1);
    spx_master_inst.stop();
    $display("change detect test done");
    sel(adr_in, 1'b0, 1'b1);
    wr(8'h01);
    spx_master_inst.stop();
    setin(v ^ 8'h80);
    wt(5);
    setin(v);
    wt(10);
    chk1(alert_n, 1'b1);
    sel(adr_in, 1'b1, 1'b1);
    rd(v, 1'b0);
    rd(8'h80, 1'b1);
    spx_master_inst.stop();
    $display("mask test done");
    sel(adr_in, 1'b1, 1'b1);
    rd(v, 1'b0);
    setin(v ^ 8'h01);
    rd(8'h00, 1'b0);
    rd(v ^ 8'h01, 1'b0);
    chk1(alert_n, 1'b1);
    rd(8'h01, 1'b1);
    spx_master_inst.stop();
    wt(20);
    chk1(alert_n, 1'b1);
    sel(adr_in, 1'b1, 1'b1);
    setin(v);
    wt(10);
    chk1(alert_n, 1'b1);
    rd(v ^ 8'h01, 1'b1);
    spx_master_inst.stop();
    wt(20);
    chk1(alert_n, 1'b0);
    $display("long read test done");
    spx_master_inst.start();
    @(posedge ref_clk_i);
    #1 bus_abort_i = 1'b1;
    wt(5);
    bus_abort_i = 1'b0;
    spx_master_inst.wr_byte({adr_in, 1'b1}, ack);
    chk1(ack, 1'b0);
    spx_master_inst.stop();
    chk1(alert_n, 1'b0);
    sel(adr_out, 1'b1, 1'b1);
    rd(d, 1'b1);
    spx_master_inst.stop();
    chk1(alert_n, 1'b1);
    $display("abort test done");
    // low select pin on the data line moves address bits 1:0 to 11
    wt(1);
    lo_on_sda = 1'b1;
    wt(10);
    sel({SPX_OUT_GROUP, 2'h2, 2'h3}, 1'b0, 1'b1);
    wr(~d);
    spx_master_inst.stop();
    wt(4);
    chk(outs, ~d);
    sel(adr_out, 1'b0, 1'b0);
    spx_master_inst.stop();
    $display("select pin test done");
    wt(10);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
